/* logic/rtcb_pkg.sv */
// constants and carrier types for the bytewide bcd clock with static ram
package rtcb_pkg;

  // ----------------------------------------------------------------
  // memory map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam logic [10:0] CLK_BASE = 11'h7f8;
  // register index within the top eight locations
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_SEC = 3'h1;
  localparam logic [2:0] IDX_MIN = 3'h2;
  localparam logic [2:0] IDX_HOUR = 3'h3;
  localparam logic [2:0] IDX_DAY = 3'h4;
  localparam logic [2:0] IDX_DATE = 3'h5;
  localparam logic [2:0] IDX_MONTH = 3'h6;
  localparam logic [2:0] IDX_YEAR = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned WR_HALT_BIT = 7;
  localparam int unsigned RD_HALT_BIT = 6;
  localparam int unsigned STOP_BIT = 7;

  // ----------------------------------------------------------------
  // bcd ranges and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] DAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] CENT_MAX = 8'h39;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SECOND_NS = 1000000000;
  localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned REFRESH_MIN_US = 500;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] century;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } rtcb_time_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic pf;
    logic [10:0] addr;
    logic [7:0] data;
  } rtcb_pins_t;

  localparam rtcb_time_t TIME_RST = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
                                      8'h00, 8'h00, 8'h00};

endpackage

/* logic/rtcb_bcd_step.sv */
// one bcd counter stage with wrap and carry
`timescale 1ns/100ps
`default_nettype none
module rtcb_bcd_step
(
  // control
  input wire logic en_i,
  input wire logic [7:0] lo_i,
  input wire logic [7:0] hi_i,
  // value
  input wire logic [7:0] val_i,
  output logic [7:0] nxt_o,
  output logic carry_o
);
  logic [7:0] inc;
  logic wrap;

  // bcd increment, units nine rolls into tens
  always_comb
  begin
    if (val_i[3:0] >= 4'h9)
      inc = {val_i[7:4] + 4'h1, 4'h0};
    else
      inc = {val_i[7:4], val_i[3:0] + 4'h1};
    // >= so a stray out of range value recovers at once
    wrap = (val_i >= hi_i);
    nxt_o = en_i ? (wrap ? lo_i : inc) : val_i;
    carry_o = en_i && wrap;
  end
endmodule
`default_nettype wire

/* logic/rtcb_core.sv */
// bytewide clock and calendar with 2k x 8 static ram behind an sram port
`timescale 1ns/100ps
`default_nettype none
// Contract
// - 2048 bytes of static memory over the address and data port.
// - clock and control registers replace the top eight locations.
// - clock registers use the same read and write cycles as memory.
// - keep century to seconds in bcd, hours in 24-hour form.
// - month lengths and leap days automatic, correct through year 2100.
// - visible copy apart from counters; accesses never disturb counting.
// - power fail deselects the port; no read or write accepted.
// - read-halt bit 6 of control stops transfers while it stays one.
// - halted registers hold captured time while counters keep running.
// - after halt, visible registers refresh together within one second.
// - write-halt bit 7 of control halts updates so host loads time.
// - clearing write-halt copies loaded values into counters and resumes.
// - seconds bit 7 stops the timebase while one; writable any time.
// - read drives data when select and output drive low, strobe high.
// - write while select and strobe low; later falling edge starts it.
module rtcb_core
  import rtcb_pkg::*;
#(
  parameter int unsigned TICK_CNT = TICK_CYCLES
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // sram style port, all asynchronous
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [10:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // supply out of tolerance
  input wire logic pwr_fail_i
);
  localparam int unsigned TW = $clog2(TICK_CNT + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CNT - 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rtcb_pins_t s1;
    rtcb_pins_t s2;
    logic wr_act;
    logic [10:0] wr_addr;
    logic [7:0] wr_data;
    rtcb_time_t cnt;
    rtcb_time_t usr;
    logic wr_halt;
    logic rd_halt;
    logic stop;
    logic [TW-1:0] tick_cnt;
    logic [7:0] dout;
    logic doe;
  } rtcb_state_t;

  rtcb_state_t q;
  rtcb_state_t d;
  rtcb_pins_t pins;
  rtcb_time_t cnt_nx;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] ram_byte;
  logic [7:0] dim;
  logic tick;
  logic tick_en;
  logic leap;
  logic leap_yr;
  logic leap_cent;
  logic rd_en;
  logic wr_now;
  logic commit;
  logic clk_hit;
  logic load;
  logic c_sec, c_min, c_hour, c_date, c_month, c_year;

  assign pins = '{ce_n_i, oe_n_i, we_n_i, pwr_fail_i, addr_i, data_i};
  assign data_o = q.dout;
  assign data_oe_o = q.doe;

  // ----------------------------------------------------------------
  // calendar chain on the internal counters
  // ----------------------------------------------------------------
  // bcd multiple of four: odd tens need units 2 or 6, even tens 0, 4 or 8
  assign leap_yr = q.cnt.year[4] ? (q.cnt.year[3:0] == 4'h2 ||
                                    q.cnt.year[3:0] == 4'h6)
                                 : (q.cnt.year[3:0] == 4'h0 ||
                                    q.cnt.year[3:0] == 4'h4 ||
                                    q.cnt.year[3:0] == 4'h8);
  assign leap_cent = q.cnt.century[4] ? (q.cnt.century[3:0] == 4'h2 ||
                                         q.cnt.century[3:0] == 4'h6)
                                      : (q.cnt.century[3:0] == 4'h0 ||
                                         q.cnt.century[3:0] == 4'h4 ||
                                         q.cnt.century[3:0] == 4'h8);
  // year 00 is leap only in a leap century, so 2000 is and 2100 is not
  assign leap = leap_yr && (q.cnt.year != BCD_ZERO || leap_cent);
  // days in the running month
  always_comb
  begin
    unique case (q.cnt.month)
      8'h02: dim = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
      default: dim = 8'h31;
    endcase
  end

  assign tick = (q.tick_cnt == TICK_LAST);
  assign tick_en = tick && !q.stop;

  // stages in bcd, hours wrap at 23
  rtcb_bcd_step u_sec (.en_i(tick_en), .lo_i(BCD_ZERO), .hi_i(SEC_MAX),
    .val_i(q.cnt.sec), .nxt_o(cnt_nx.sec), .carry_o(c_sec));
  rtcb_bcd_step u_min (.en_i(c_sec), .lo_i(BCD_ZERO), .hi_i(MIN_MAX),
    .val_i(q.cnt.min), .nxt_o(cnt_nx.min), .carry_o(c_min));
  rtcb_bcd_step u_hour (.en_i(c_min), .lo_i(BCD_ZERO), .hi_i(HOUR_MAX),
    .val_i(q.cnt.hour), .nxt_o(cnt_nx.hour), .carry_o(c_hour));
  rtcb_bcd_step u_day (.en_i(c_hour), .lo_i(BCD_ONE), .hi_i(DAY_MAX),
    .val_i(q.cnt.day), .nxt_o(cnt_nx.day), .carry_o());
  rtcb_bcd_step u_date (.en_i(c_hour), .lo_i(BCD_ONE), .hi_i(dim),
    .val_i(q.cnt.date), .nxt_o(cnt_nx.date), .carry_o(c_date));
  rtcb_bcd_step u_month (.en_i(c_date), .lo_i(BCD_ONE), .hi_i(MONTH_MAX),
    .val_i(q.cnt.month), .nxt_o(cnt_nx.month), .carry_o(c_month));
  rtcb_bcd_step u_year (.en_i(c_month), .lo_i(BCD_ZERO), .hi_i(YEAR_MAX),
    .val_i(q.cnt.year), .nxt_o(cnt_nx.year), .carry_o(c_year));
  rtcb_bcd_step u_cent (.en_i(c_year), .lo_i(BCD_ZERO), .hi_i(CENT_MAX),
    .val_i(q.cnt.century), .nxt_o(cnt_nx.century), .carry_o());

  // ----------------------------------------------------------------
  // port decode, transfers and register writes
  // ----------------------------------------------------------------
  assign ram_byte = mem[q.s2.addr];

  always_comb
  begin
    d = q;
    // two flops on every pin before use
    d.s1 = pins;
    d.s2 = q.s1;
    rd_en = !q.s2.ce_n && !q.s2.oe_n && q.s2.we_n &&
            !q.s2.pf;
    wr_now = !q.s2.ce_n && !q.s2.we_n && !q.s2.pf;
    d.wr_act = wr_now;
    // track address and data while the strobe is low, commit at its end
    if (wr_now)
    begin
      d.wr_addr = q.s2.addr;
      d.wr_data = q.s2.data;
    end
    // a power fail inside the cycle drops the write
    commit = q.wr_act && !wr_now && !q.s2.pf;
    clk_hit = commit && (q.wr_addr >= CLK_BASE);
    load = clk_hit && (q.wr_addr[2:0] == IDX_CTRL) && q.wr_halt &&
           !q.wr_data[WR_HALT_BIT];
    // timebase keeps its phase while stopped
    if (!q.stop)
      d.tick_cnt = tick ? '0 : q.tick_cnt + TW'(1);
    d.cnt = cnt_nx;
    // visible copy follows the counters only with both halts clear
    if (!q.rd_halt && !q.wr_halt)
      d.usr = cnt_nx;
    if (clk_hit)
    begin
      unique case (q.wr_addr[2:0])
        IDX_CTRL:
        begin
          d.wr_halt = q.wr_data[WR_HALT_BIT];
          d.rd_halt = q.wr_data[RD_HALT_BIT];
          d.usr.century = {2'b00, q.wr_data[5:0]};
        end
        IDX_SEC:
        begin
          d.stop = q.wr_data[STOP_BIT];
          d.usr.sec = {1'b0, q.wr_data[6:0]};
        end
        IDX_MIN: d.usr.min = q.wr_data;
        IDX_HOUR: d.usr.hour = q.wr_data;
        IDX_DAY: d.usr.day = q.wr_data;
        IDX_DATE: d.usr.date = q.wr_data;
        IDX_MONTH: d.usr.month = q.wr_data;
        IDX_YEAR: d.usr.year = q.wr_data;
      endcase
    end
    // loaded values take over the counters as write-halt drops
    if (load)
      d.cnt = q.usr;
    // read data mux, registered onto the pins
    d.doe = rd_en;
    if (q.s2.addr < CLK_BASE)
      d.dout = ram_byte;
    else
    begin
      unique case (q.s2.addr[2:0])
        IDX_CTRL: d.dout = {q.wr_halt, q.rd_halt, q.usr.century[5:0]};
        IDX_SEC: d.dout = {q.stop, q.usr.sec[6:0]};
        IDX_MIN: d.dout = q.usr.min;
        IDX_HOUR: d.dout = q.usr.hour;
        IDX_DAY: d.dout = q.usr.day;
        IDX_DATE: d.dout = q.usr.date;
        IDX_MONTH: d.dout = q.usr.month;
        IDX_YEAR: d.dout = q.usr.year;
      endcase
    end
  end

  // state register; pins idle high so nothing starts out of reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
      q.s1 <= '{1'b1, 1'b1, 1'b1, 1'b1, 11'h000, 8'h00};
      q.s2 <= '{1'b1, 1'b1, 1'b1, 1'b1, 11'h000, 8'h00};
      q.cnt <= TIME_RST;
      q.usr <= TIME_RST;
    end
    else
      q <= d;
  end

  // plain storage below the clock registers, not reset
  always_ff @(posedge clk_i)
  begin
    if (commit && (q.wr_addr < CLK_BASE))
      mem[q.wr_addr] <= q.wr_data;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_PF_DESELECT: assert property (
    q.s2.pf |=> !data_oe_o)
    else $error("port drove data during power fail");
  AST_READ_DRIVE: assert property (
    (!q.s2.ce_n && !q.s2.oe_n && q.s2.we_n && !q.s2.pf) |=> data_oe_o)
    else $error("read cycle did not drive data");
  AST_RD_HOLD: assert property (
    (q.rd_halt && !clk_hit) |=> $stable(q.usr))
    else $error("visible registers moved under read halt");
  AST_REFRESH: assert property (
    (!q.rd_halt && !q.wr_halt && !clk_hit) |=> (q.usr == $past(cnt_nx)))
    else $error("visible registers missed refresh");
  AST_COUNT_ON: assert property (
    (tick_en && q.cnt.sec != SEC_MAX && !load) |=>
      (q.cnt.sec != $past(q.cnt.sec)))
    else $error("counter did not advance on tick");
  AST_STOP: assert property (
    (q.stop && !load) |=> $stable(q.cnt))
    else $error("counters advanced while stopped");
  AST_WR_LOAD: assert property (
    load |=> (q.cnt == $past(q.usr)))
    else $error("write halt release did not load counters");
  AST_HOUR_RANGE: assert property (
    (q.cnt.hour <= HOUR_MAX) |=> (q.cnt.hour <= HOUR_MAX || $past(load)))
    else $error("hour left 24 hour range");
  AST_RAM_WRITE: assert property (
    (commit && q.wr_addr < CLK_BASE) |=>
      (mem[$past(q.wr_addr)] == $past(q.wr_data)))
    else $error("ram byte not stored");
  AST_WR_HALT: assert property (
    (q.wr_halt && !clk_hit) |=> $stable(q.usr))
    else $error("visible registers moved under write halt");
endmodule
`default_nettype wire

/* tb/rtcb_host.sv */
// host bus model driving the sram style port of the clock block
`timescale 1ns/100ps
`default_nettype none
module rtcb_host
  import rtcb_pkg::*;
(
  // clock and returned data
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i,
  // pins toward the device
  output var rtcb_pins_t pins_o
);
  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // deselected and quiet from time zero
  initial
  begin
    pins_o = '{1'b1, 1'b1, 1'b1, 1'b0, 11'h000, 8'h00};
  end

  // supply monitor level, changed off the sampling edge
  task automatic set_pf(input logic v);
    @(negedge clk_i);
    pins_o.pf = v;
  endtask

  // one cycle shape for ram and clock bytes alike
  task automatic wr(input logic [10:0] a, input logic [7:0] d,
                    input logic ce_late);
    @(negedge clk_i);
    pins_o.addr = a;
    pins_o.data = d;
    pins_o.we_n = 1'b0;
    pins_o.ce_n = ce_late;
    @(negedge clk_i);
    pins_o.ce_n = 1'b0;
    repeat (4) @(negedge clk_i);
    pins_o.we_n = 1'b1;
    pins_o.ce_n = 1'b1;
    // data held past the strobe, then scrambled so stale data cannot pass
    repeat (2) @(negedge clk_i);
    pins_o.data = ~d;
    repeat (3) @(negedge clk_i);
  endtask

  // read waits a bounded time for the device to drive the pins
  task automatic rd(input logic [10:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    d = 'x;
    ok = 1'b0;
    n = 0;
    @(negedge clk_i);
    pins_o.addr = a;
    pins_o.ce_n = 1'b0;
    pins_o.oe_n = 1'b0;
    while (!ok && n < 8)
    begin
      @(negedge clk_i);
      n++;
      if (data_oe_i === 1'b1)
      begin
        ok = 1'b1;
        d = data_i;
      end
    end
    pins_o.oe_n = 1'b1;
    pins_o.ce_n = 1'b1;
    repeat (4) @(negedge clk_i);
    // the device must have let go of the pins by now
    if (data_oe_i !== 1'b0)
      ok = 1'b0;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the bytewide clock with static ram
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module tb;
  import rtcb_pkg::*;
  // ----------------------------------------------------------------
  // harness
  // ----------------------------------------------------------------
  // short second so calendar rollovers fit in the run
  localparam int unsigned TICKS = 8;
  logic clk;
  logic rst_n;
  rtcb_pins_t pins;
  logic [7:0] dq_o;
  logic dq_oe;
  logic [7:0] dq_bus;
  int n_fail;
  int total_checks;

  // data pins: device level while it drives, host level otherwise
  assign dq_bus = dq_oe ? dq_o : pins.data;

  rtcb_core #(.TICK_CNT(TICKS)) uut
  (
    .clk_i(clk),
    .rst_n_i(rst_n),
    .ce_n_i(pins.ce_n),
    .oe_n_i(pins.oe_n),
    .we_n_i(pins.we_n),
    .addr_i(pins.addr),
    .data_i(dq_bus),
    .data_o(dq_o),
    .data_oe_o(dq_oe),
    .pwr_fail_i(pins.pf)
  );

  rtcb_host host
  (
    .clk_i(clk),
    .data_i(dq_bus),
    .data_oe_i(dq_oe),
    .pins_o(pins)
  );

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // bottom, middle and top byte below the clock registers
  task automatic ram_check();
    logic [10:0] ad [3];
    logic [7:0] dv [3];
    logic [7:0] v;
    logic ok;
    ad = '{11'h000, 11'h3a5, 11'h7f7};
    dv = '{8'h3c, 8'hc3, 8'h5a};
    for (int i = 0; i < 3; i++)
      host.wr(ad[i], dv[i], i == 0);
    for (int i = 0; i < 3; i++)
    begin
      host.rd(ad[i], v, ok);
      `CHK("ram byte", dv[i], v);
      `CHK("ram read released", 1'b1, ok);
    end
  endtask

  // a supply fault must refuse both kinds of access
  task automatic pf_check();
    logic [7:0] v;
    logic ok;
    host.set_pf(1'b1);
    host.wr(11'h3a5, 8'h00, 1'b0);
    host.rd(11'h3a5, v, ok);
    `CHK("read driven in fault", 1'b0, ok);
    host.set_pf(1'b0);
    host.rd(11'h3a5, v, ok);
    `CHK("ram after fault", 8'hc3, v);
  endtask

  // load 23:59:58 stopped, run across midnight, then freeze and read
  task automatic time_check(input logic [7:0] yr, input logic [7:0] mo,
                            input logic [7:0] dt, input logic [7:0] e_mo,
                            input logic [7:0] e_dt);
    logic [7:0] ld [1:7];
    logic [7:0] v;
    logic [7:0] held;
    logic ok;
    ld = '{8'hd8, 8'h59, 8'h23, 8'h07, dt, mo, yr};
    host.wr(CLK_BASE, 8'ha0, 1'b0);
    for (int i = 1; i < 8; i++)
      host.wr(CLK_BASE + 11'(i), ld[i], 1'b0);
    for (int i = 1; i < 8; i++)
    begin
      host.rd(CLK_BASE + 11'(i), v, ok);
      `CHK("loaded reg", ld[i], v);
    end
    host.wr(CLK_BASE, 8'h20, 1'b0);
    repeat (40) @(negedge clk);
    host.rd(CLK_BASE + 11'h1, v, ok);
    `CHK("stopped sec", 8'hd8, v);
    host.rd(CLK_BASE + 11'h2, v, ok);
    `CHK("loaded min", 8'h59, v);
    host.wr(CLK_BASE + 11'h1, 8'h58, 1'b0);
    repeat (40) @(negedge clk);
    host.wr(CLK_BASE, 8'h60, 1'b0);
    host.rd(CLK_BASE + 11'h6, v, ok);
    `CHK("month", e_mo, v);
    host.rd(CLK_BASE + 11'h5, v, ok);
    `CHK("date", e_dt, v);
    host.rd(CLK_BASE + 11'h3, v, ok);
    `CHK("hour", 8'h00, v);
    host.rd(CLK_BASE + 11'h4, v, ok);
    `CHK("day", 8'h01, v);
    host.rd(CLK_BASE + 11'h1, held, ok);
    repeat (40) @(negedge clk);
    host.rd(CLK_BASE + 11'h1, v, ok);
    `CHK("held sec", held, v);
    `CHK("held read ok", 1'b1, ok);
    // counters ran on unseen; about 2570 s after start gives minute 42
    host.wr(CLK_BASE, 8'h20, 1'b0);
    repeat (20400) @(negedge clk);
    host.wr(CLK_BASE, 8'h60, 1'b0);
    host.rd(CLK_BASE + 11'h2, v, ok);
    `CHK("minute after run", 8'h42, v);
    host.rd(CLK_BASE, v, ok);
    `CHK("control", 8'h60, v);
    host.wr(CLK_BASE, 8'h20, 1'b0);
  endtask

  // closing report, the only place the run ends
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // main sequence: leap year, common year, thirty day month
  initial
  begin
    n_fail = 0;
    total_checks = 0;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    ram_check();
    pf_check();
    time_check(8'h00, 8'h02, 8'h28, 8'h02, 8'h29);
    time_check(8'h01, 8'h02, 8'h28, 8'h03, 8'h01);
    time_check(8'h01, 8'h04, 8'h30, 8'h05, 8'h01);
    conclude();
  end
endmodule
`default_nettype wire
